// *** ihd_host_decode.sv ***
// isa host address decode, buffer access routing, irq steering and indicators
`timescale 1ns/100ps
`include "ihd_regs.svh"
module ihd_host_decode #(
  parameter int AW = 10
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [23:0] isa_addr,
  input wire logic sbhe_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [2:0] io_block_select_straps,
  input wire logic [4:0] memory_segment_select_straps,
  input wire logic boot_rom_enable_strap,
  input wire logic memory_enable_wide_strap,
  input wire logic [3:0] irq_select_straps,
  input wire logic cfg_io_access,
  input wire logic cfg_decode_mode,
  input wire logic cfg_wide_bus,
  input wire logic node_id_loaded,
  input wire logic irq_req,
  input wire logic tx_active,
  input wire logic [7:0] io_reg_rd_data,
  output logic io_reg_rd,
  output logic io_reg_wr,
  output logic [3:0] io_reg_index,
  output logic [7:0] io_reg_wr_data,
  output logic io_sel,
  output logic ram_sel,
  output logic rom_sel,
  output logic memcs16_n,
  output logic [`IHD_IRQ_LINES-1:0] irq_lines,
  output logic tx_led,
  output logic access_led
);
  ihd_pkg::ihd_cycle_t cyc_q;
  logic [11:0] io_base;
  logic [5:0] seg_base;
  logic [4:0] ms_idx;
  logic [8:0] ram_cmp;
  logic low_mb, seg_hit, ram_win, ram_hit, rom_hit, wide;
  logic ram_enabled_q, wide_strap_q;
  logic [10:0] ptr_q, baddr;
  logic [15:0] rdata, wdata;
  logic we_lo, we_hi, start_io_rd, start_io_wr, start_mem_rd, start_mem_wr;
  logic data_port, ptr_step;

  always_comb begin
    case (io_block_select_straps ^ `IHD_IOS_XOR)
      3'h0: io_base = `IHD_IO_BASE_0;
      3'h1: io_base = `IHD_IO_BASE_1;
      3'h2: io_base = `IHD_IO_BASE_2;
      3'h3: io_base = `IHD_IO_BASE_3;
      3'h4: io_base = `IHD_IO_BASE_4;
      3'h5: io_base = `IHD_IO_BASE_5;
      3'h6: io_base = `IHD_IO_BASE_6;
      default: io_base = `IHD_IO_BASE_7;
    endcase
  end

  assign ms_idx = memory_segment_select_straps ^ `IHD_MS_XOR;

  always_comb begin
    case (ms_idx[4:2])
      3'h0: seg_base = `IHD_SEG_0;
      3'h1: seg_base = `IHD_SEG_1;
      3'h2: seg_base = `IHD_SEG_2;
      3'h3: seg_base = `IHD_SEG_3;
      3'h4: seg_base = `IHD_SEG_4;
      3'h5: seg_base = `IHD_SEG_5;
      3'h6: seg_base = `IHD_SEG_6;
      default: seg_base = `IHD_SEG_7;
    endcase
  end

  // the zero in bit 13 keeps the ram in the lower 8K of the segment
  assign ram_cmp = {seg_base, 1'b0, ms_idx[1:0]};
  assign low_mb = (isa_addr[23:20] == 4'h0);
  assign io_sel = (isa_addr[15:4] == io_base);
  assign seg_hit = low_mb && (isa_addr[19:14] == seg_base);
  assign ram_win = low_mb && (isa_addr[19:11] == ram_cmp);
  assign ram_hit = ram_win && !cfg_io_access && ram_enabled_q;
  // in I/O mode the rom may claim the whole segment, ram space included
  assign rom_hit = boot_rom_enable_strap && seg_hit
    && (isa_addr[13] || (cfg_io_access && cfg_decode_mode));
  assign ram_sel = ram_hit && (!memr_n || !memw_n);
  assign rom_sel = rom_hit && !memr_n;
  assign wide = wide_strap_q || cfg_wide_bus;

  always_comb begin
    memcs16_n = 1'b1;
    if (!cfg_io_access && wide && ram_enabled_q) begin
      if (cfg_decode_mode) begin
        memcs16_n = !(low_mb && isa_addr[19:17] == seg_base[5:3]);
      end else begin
        memcs16_n = !ram_win;
      end
    end
  end

  // strap is caught by the synchronous reset, so no software reset is needed
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wide_strap_q <= memory_enable_wide_strap;
      ram_enabled_q <= memory_enable_wide_strap;
    end else if (node_id_loaded) begin
      ram_enabled_q <= 1'b1;
    end
  end

  assign start_io_rd = (cyc_q == ihd_pkg::IHD_IDLE) && !ior_n && io_sel;
  assign start_io_wr = (cyc_q == ihd_pkg::IHD_IDLE) && !iow_n && io_sel;
  assign start_mem_rd = (cyc_q == ihd_pkg::IHD_IDLE) && !memr_n && ram_hit;
  assign start_mem_wr = (cyc_q == ihd_pkg::IHD_IDLE) && !memw_n && ram_hit;
  assign data_port = (isa_addr[3:0] == `IHD_OFS_DATA) && cfg_io_access && ram_enabled_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cyc_q <= ihd_pkg::IHD_IDLE;
    end else begin
      case (cyc_q)
        ihd_pkg::IHD_IDLE: begin
          if (start_io_rd) cyc_q <= ihd_pkg::IHD_IO_RD;
          else if (start_io_wr) cyc_q <= ihd_pkg::IHD_IO_WR;
          else if (start_mem_rd) cyc_q <= ihd_pkg::IHD_MEM_RD;
          else if (start_mem_wr) cyc_q <= ihd_pkg::IHD_MEM_WR;
        end
        ihd_pkg::IHD_IO_RD: if (ior_n) cyc_q <= ihd_pkg::IHD_IDLE;
        ihd_pkg::IHD_MEM_RD: if (memr_n) cyc_q <= ihd_pkg::IHD_IDLE;
        ihd_pkg::IHD_IO_WR, ihd_pkg::IHD_MEM_WR, ihd_pkg::IHD_WAIT: begin
          // writes act once on entry, then wait out the strobe
          if (iow_n && memw_n) cyc_q <= ihd_pkg::IHD_IDLE;
          else cyc_q <= ihd_pkg::IHD_WAIT;
        end
        default: cyc_q <= ihd_pkg::IHD_IDLE;
      endcase
    end
  end

  // data port write steps at once, data port read steps when the strobe ends
  assign ptr_step = (start_io_wr && data_port)
    || (cyc_q == ihd_pkg::IHD_IO_RD && ior_n && data_port);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ptr_q <= `IHD_PTR_RESET;
    end else if (start_io_wr && cfg_io_access && isa_addr[3:0] == `IHD_OFS_PTR_LO) begin
      ptr_q <= {ptr_q[10:8], data_in[7:0]};
    end else if (start_io_wr && cfg_io_access && isa_addr[3:0] == `IHD_OFS_PTR_HI) begin
      ptr_q <= {data_in[2:0], ptr_q[7:0]};
    end else if (ptr_step) begin
      ptr_q <= ptr_q + (wide ? 11'h002 : 11'h001);
    end
  end

  assign baddr = cfg_io_access ? ptr_q : isa_addr[10:0];
  assign wdata = wide ? data_in : {data_in[7:0], data_in[7:0]};
  assign we_lo = (start_mem_wr || (start_io_wr && data_port)) && !baddr[0];
  // in 16-bit mode a word write also fills the high lane
  assign we_hi = (start_mem_wr || (start_io_wr && data_port))
    && (baddr[0] || (wide && !sbhe_n));

  ihd_buffer_ram #(
    .AW(AW)
  ) u_ram (
    .mclk(mclk),
    .we_lo(we_lo),
    .we_hi(we_hi),
    .addr(baddr[AW:1]),
    .wdata(wdata),
    .rdata(rdata)
  );

  // read data lags the strobe by two clocks; far shorter than an isa cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      data_out <= 16'h0000;
    end else if (cyc_q == ihd_pkg::IHD_MEM_RD || (cyc_q == ihd_pkg::IHD_IO_RD && data_port)) begin
      if (wide && !baddr[0]) data_out <= rdata;
      else if (baddr[0]) data_out <= {rdata[15:8], rdata[15:8]};
      else data_out <= {rdata[7:0], rdata[7:0]};
    end else if (cyc_q == ihd_pkg::IHD_IO_RD && cfg_io_access && isa_addr[3:0] == `IHD_OFS_PTR_LO) begin
      data_out <= {8'h00, ptr_q[7:0]};
    end else if (cyc_q == ihd_pkg::IHD_IO_RD && cfg_io_access && isa_addr[3:0] == `IHD_OFS_PTR_HI) begin
      data_out <= {13'h0000, ptr_q[10:8]};
    end else if (cyc_q == ihd_pkg::IHD_IO_RD) begin
      data_out <= {8'h00, io_reg_rd_data};
    end
  end

  assign data_oe = (cyc_q == ihd_pkg::IHD_IO_RD) || (cyc_q == ihd_pkg::IHD_MEM_RD);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      io_reg_rd <= 1'b0;
      io_reg_wr <= 1'b0;
      io_reg_index <= 4'h0;
      io_reg_wr_data <= 8'h00;
    end else begin
      io_reg_rd <= start_io_rd;
      io_reg_wr <= start_io_wr;
      if (start_io_rd || start_io_wr) begin
        io_reg_index <= isa_addr[3:0];
        io_reg_wr_data <= data_in[7:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `IHD_IRQ_LINES; gi++) begin : g_irq
      always_ff @(posedge mclk) begin
        if (!reset_n) irq_lines[gi] <= 1'b0;
        else irq_lines[gi] <= irq_req && (irq_select_straps == 4'(gi));
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tx_led <= 1'b0;
      access_led <= 1'b0;
    end else begin
      tx_led <= tx_active;
      access_led <= (cyc_q != ihd_pkg::IHD_IDLE);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_data_wr;
    start_io_wr && data_port && !wide;
  endsequence
  sequence s_io_rd_end;
    cyc_q == ihd_pkg::IHD_IO_RD && ior_n && data_port && wide;
  endsequence

  property p_io_default;
    io_block_select_straps == 3'h7 && io_sel |-> isa_addr[15:4] == 12'h030;
  endproperty
  a_io_default: assert property (p_io_default) else $error("default io block not at 0300h");
  property p_low_mb;
    ram_sel || rom_sel |-> isa_addr[23:20] == 4'h0;
  endproperty
  a_low_mb: assert property (p_low_mb) else $error("memory select above 1 MB");
  property p_hidden;
    !ram_enabled_q |-> !ram_sel && !we_lo && !we_hi;
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden ram was accessed");
  property p_strap;
    $past(!reset_n) && $past(memory_enable_wide_strap) |-> ram_enabled_q && wide;
  endproperty
  a_strap: assert property (p_strap) else $error("strap did not enable wide memory");
  property p_io_mode;
    cfg_io_access |-> !ram_sel && memcs16_n;
  endproperty
  a_io_mode: assert property (p_io_mode) else $error("memory mapped ram in io mode");
  property p_ptr_narrow;
    s_data_wr |=> ptr_q == $past(ptr_q) + 11'h001;
  endproperty
  a_ptr_narrow: assert property (p_ptr_narrow) else $error("byte pointer did not step by one");
  property p_ptr_wide;
    s_io_rd_end |=> ptr_q == $past(ptr_q) + 11'h002;
  endproperty
  a_ptr_wide: assert property (p_ptr_wide) else $error("word pointer did not step by two");
  property p_irq;
    irq_req && irq_select_straps < 4'hB |=> $onehot(irq_lines);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not on exactly one line");
  property p_led;
    tx_active ##1 tx_active |-> tx_led;
  endproperty
  a_led: assert property (p_led) else $error("transmit indicator dark");
  property p_rom_a13;
    rom_sel && !cfg_io_access |-> isa_addr[13] && !ram_sel;
  endproperty
  a_rom_a13: assert property (p_rom_a13) else $error("rom selected with A13 low");
endmodule // ihd_host_decode

// *** ihd_regs.svh ***
// constants for the isa host decode block: strap tables, internal offsets, reset values
//
// Operation
// - I/O space is one 16-byte block aligned on a 16-byte boundary.
// - I/O straps give a 12-bit base compared against address lines A15..A4.
// - Eight I/O bases from 0260h to 03E0h; default strap position gives 0300h.
// - Buffer RAM and boot ROM sit in a 16K segment below 1 MB only.
// - Buffer RAM stays hidden from the host until a node ID is loaded or the memory-enable strap is caught at reset.
// - Memory-enable strap starts the part in 16-bit mode with memory enabled.
// - I/O access bit picks sequential I/O access or direct memory mapping.
// - Decode bit picks 8K/16K ROM, or 2K/128K range for the 16-bit select.
// - In 16-bit bus mode the buffer appears as 1K 16-bit words.
// - Interrupt request goes onto the one strap-selected host line of eleven; strap values 11 to 15 select none.
// - Transmit indicator lights when sending; access indicator lights on host I/O block or buffer RAM access, not on ROM reads.
// - Inside the segment, A13 high selects ROM; A13 low selects the 2K RAM window, or ROM in I/O mode with the decode bit set.
// - Five segment straps give a 9-bit value compared against A19..A11.
`ifndef IHD_REGS_SVH
`define IHD_REGS_SVH

// strap index is the raw strap value xor this, so open straps land on the default row
`define IHD_IOS_XOR 3'h3
`define IHD_MS_XOR 5'h13

// I/O block bases, address bits 15..4
`define IHD_IO_BASE_0 12'h026
`define IHD_IO_BASE_1 12'h029
`define IHD_IO_BASE_2 12'h02E
`define IHD_IO_BASE_3 12'h02F
`define IHD_IO_BASE_4 12'h030
`define IHD_IO_BASE_5 12'h035
`define IHD_IO_BASE_6 12'h038
`define IHD_IO_BASE_7 12'h03E

// 16K segment bases, address bits 19..14
`define IHD_SEG_0 6'h30
`define IHD_SEG_1 6'h31
`define IHD_SEG_2 6'h33
`define IHD_SEG_3 6'h34
`define IHD_SEG_4 6'h35
`define IHD_SEG_5 6'h36
`define IHD_SEG_6 6'h37
`define IHD_SEG_7 6'h38

// internal byte registers inside the I/O block
`define IHD_OFS_PTR_LO 4'h2
`define IHD_OFS_PTR_HI 4'h3
`define IHD_OFS_DATA 4'h4

`define IHD_PTR_RESET 11'h000
`define IHD_IRQ_LINES 11

`endif

// *** ihd_pkg.sv ***
// types shared by the isa host decode block
package ihd_pkg;
  typedef enum logic [2:0] {
    IHD_IDLE,
    IHD_IO_RD,
    IHD_IO_WR,
    IHD_MEM_RD,
    IHD_MEM_WR,
    IHD_WAIT
  } ihd_cycle_t;
endpackage

// *** ihd_buffer_ram.sv ***
// word-wide buffer ram with byte lane writes and registered read data
`timescale 1ns/100ps
module ihd_buffer_ram #(
  parameter int AW = 10
) (
  input wire logic mclk,
  input wire logic we_lo,
  input wire logic we_hi,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [7:0] lo_mem [0:(1<<AW)-1];
  logic [7:0] hi_mem [0:(1<<AW)-1];

  always_ff @(posedge mclk) begin
    if (we_lo) begin
      lo_mem[addr] <= wdata[7:0];
    end
    if (we_hi) begin
      hi_mem[addr] <= wdata[15:8];
    end
    rdata <= {hi_mem[addr], lo_mem[addr]};
  end
endmodule // ihd_buffer_ram

// *** ihd_host_model.sv ***
// behavioural isa host that runs single bus cycles against the decode block
`timescale 1ns/100ps
module ihd_host_model (
  input wire logic mclk,
  output logic [23:0] isa_addr,
  output logic sbhe_n,
  output logic ior_n,
  output logic iow_n,
  output logic memr_n,
  output logic memw_n,
  output logic [15:0] data_in
);
  initial begin
    isa_addr = 24'h000000;
    sbhe_n = 1'b1;
    {ior_n, iow_n, memr_n, memw_n} = 4'hF;
    data_in = 16'h0000;
  end

  // kind 0 io read, 1 io write, 2 mem read, 3 mem write, 4 address only; returns after the taking edge
  task automatic start(input int k, input logic [23:0] a, input logic [15:0] wd);
    logic [3:0] s;
    s = 4'h8 >> k;
    @(posedge mclk);
    isa_addr <= a;
    sbhe_n <= 1'b0;
    data_in <= wd;
    {ior_n, iow_n, memr_n, memw_n} <= ~s;
    @(posedge mclk);
  endtask

  // released data lines do not keep the last value, so a stale sample shows up as wrong data
  task automatic stop();
    @(posedge mclk);
    {ior_n, iow_n, memr_n, memw_n} <= 4'hF;
    sbhe_n <= 1'b1;
    data_in <= ~data_in;
    @(posedge mclk);
  endtask
endmodule // ihd_host_model

// *** testbench.sv ***
// self-checking bench for the isa host decode block
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [23:0] isa_addr;
  logic sbhe_n, ior_n, iow_n, memr_n, memw_n;
  logic [15:0] data_in, data_out;
  logic data_oe, io_reg_rd, io_reg_wr, io_sel, ram_sel, rom_sel, memcs16_n, tx_led, access_led;
  logic [2:0] ios = 3'h7;
  logic [4:0] mss = 5'h1F;
  logic wide_strap = 1'b0, cfg_io = 1'b0, cfg_dm = 1'b0, cfg_wide = 1'b0, node_ld = 1'b0;
  logic irq_req = 1'b0, tx_active = 1'b0, rom_en = 1'b1;
  logic [3:0] irq_sel = 4'h0, io_reg_index;
  logic [7:0] io_reg_wr_data;
  logic [10:0] irq_lines;
  int err_total = 0;
  int compares = 0;
  logic [11:0] iob [8] = '{12'h026, 12'h029, 12'h02E, 12'h02F, 12'h030, 12'h035, 12'h038, 12'h03E};
  logic [23:0] ma [4] = '{24'h0D0000, 24'h0D0800, 24'h0D0800, 24'h0E0000};
  logic mx [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  always #5 mclk = ~mclk;

  ihd_host_model host (.mclk(mclk), .isa_addr(isa_addr), .sbhe_n(sbhe_n), .ior_n(ior_n), .iow_n(iow_n),
    .memr_n(memr_n), .memw_n(memw_n), .data_in(data_in));

  ihd_host_decode uut (.mclk(mclk), .reset_n(reset_n), .isa_addr(isa_addr), .sbhe_n(sbhe_n), .ior_n(ior_n),
    .iow_n(iow_n), .memr_n(memr_n), .memw_n(memw_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .io_block_select_straps(ios), .memory_segment_select_straps(mss),
    .boot_rom_enable_strap(rom_en), .memory_enable_wide_strap(wide_strap), .irq_select_straps(irq_sel),
    .cfg_io_access(cfg_io), .cfg_decode_mode(cfg_dm), .cfg_wide_bus(cfg_wide), .node_id_loaded(node_ld),
    .irq_req(irq_req), .tx_active(tx_active), .io_reg_rd_data(8'hC3), .io_reg_rd(io_reg_rd),
    .io_reg_wr(io_reg_wr), .io_reg_index(io_reg_index), .io_reg_wr_data(io_reg_wr_data), .io_sel(io_sel),
    .ram_sel(ram_sel), .rom_sel(rom_sel), .memcs16_n(memcs16_n), .irq_lines(irq_lines), .tx_led(tx_led),
    .access_led(access_led));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic w);
    @(posedge mclk);
    wide_strap <= w;
    reset_n <= 1'b0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask

  // one claimed mem or io read, sampled when the data is due
  task automatic rd_chk(input int k, input logic [23:0] a, input logic [15:0] exp);
    host.start(k, a, 16'h0000);
    repeat (2) @(posedge mclk);
    #1 chk("read data", data_out, exp);
    chk("data_oe", {15'h0, data_oe}, 16'h1);
    host.stop();
    // the cycle has ended by the edge that stop returns on, so the drive must be off
    #1 chk("data_oe off", {15'h0, data_oe}, 16'h0);
  endtask

  task automatic sel_chk(input logic [23:0] a, input logic ram_x, input logic rom_x);
    host.start(2, a, 16'h0000);
    #1 chk("ram_sel", {15'h0, ram_sel}, {15'h0, ram_x});
    chk("rom_sel", {15'h0, rom_sel}, {15'h0, rom_x});
    host.stop();
  endtask

  task automatic t_io_decode();
    for (int s = 0; s < 8; s++) begin
      @(posedge mclk);
      ios <= s[2:0];
      host.start(1, {8'h00, iob[s ^ 3], 4'h8 + s[3:0]}, 16'h00A0 + s[15:0]);
      #1 chk("io_sel", {15'h0, io_sel}, 16'h1);
      chk("io_reg_wr", {15'h0, io_reg_wr}, 16'h1);
      chk("io_reg_index", {12'h0, io_reg_index}, 16'h8 + s[15:0]);
      chk("io_reg_wr_data", {8'h00, io_reg_wr_data}, 16'h00A0 + s[15:0]);
      @(posedge mclk);
      #1 chk("access_led", {15'h0, access_led}, 16'h1);
      host.stop();
      host.start(4, {8'h00, iob[s ^ 3] + 12'h001, 4'h0}, 16'h0000);
      #1 chk("io_sel next block", {15'h0, io_sel}, 16'h0);
      host.stop();
    end
    repeat (2) @(posedge mclk);
    #1 chk("access_led idle", {15'h0, access_led}, 16'h0);
  endtask

  task automatic t_irq_leds();
    for (int i = 0; i < 11; i++) begin
      @(posedge mclk);
      irq_sel <= i[3:0];
      irq_req <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk("irq_lines", {5'h00, irq_lines}, 16'h1 << i);
    end
    @(posedge mclk);
    irq_req <= 1'b0;
    tx_active <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk("tx_led", {15'h0, tx_led}, 16'h1);
    chk("irq_lines off", {5'h00, irq_lines}, 16'h0000);
    @(posedge mclk);
    tx_active <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("tx_led off", {15'h0, tx_led}, 16'h0);
  endtask

  task automatic t_mem();
    sel_chk(24'h0D0000, 1'b0, 1'b0);
    @(posedge mclk);
    node_ld <= 1'b1;
    @(posedge mclk);
    node_ld <= 1'b0;
    cfg_wide <= 1'b1;
    host.start(3, 24'h0D0002, 16'h1234);
    host.stop();
    rd_chk(2, 24'h0D0002, 16'h1234);
    rd_chk(2, 24'h0D0003, 16'h1212);
    sel_chk(24'h1D0000, 1'b0, 1'b0);
    sel_chk(24'h0D2000, 1'b0, 1'b1);
    @(posedge mclk);
    rom_en <= 1'b0;
    sel_chk(24'h0D2000, 1'b0, 1'b0);
    @(posedge mclk);
    rom_en <= 1'b1;
    sel_chk(24'h1D2000, 1'b0, 1'b0);
    @(posedge mclk);
    mss <= 5'h1E;
    sel_chk(24'h0D0800, 1'b1, 1'b0);
    sel_chk(24'h0D0000, 1'b0, 1'b0);
    @(posedge mclk);
    mss <= 5'h1F;
    for (int j = 0; j < 4; j++) begin
      @(posedge mclk);
      cfg_dm <= j[1];
      host.start(4, ma[j], 16'h0000);
      #1 chk("memcs16_n", {15'h0, memcs16_n}, {15'h0, mx[j]});
      host.stop();
    end
  endtask

  task automatic io_wr(input logic [3:0] o, input logic [7:0] d);
    host.start(1, {8'h00, 12'h030, o}, {8'h00, d});
    host.stop();
  endtask

  task automatic t_io_seq();
    @(posedge mclk);
    cfg_io <= 1'b1;
    cfg_wide <= 1'b0;
    sel_chk(24'h0D0000, 1'b0, 1'b1);
    @(posedge mclk);
    cfg_dm <= 1'b0;
    sel_chk(24'h0D0000, 1'b0, 1'b0);
    io_wr(4'h2, 8'h10);
    io_wr(4'h3, 8'h00);
    io_wr(4'h4, 8'hA5);
    io_wr(4'h4, 8'h5A);
    io_wr(4'h2, 8'h10);
    rd_chk(0, 24'h000304, 16'hA5A5);
    rd_chk(0, 24'h000304, 16'h5A5A);
    rd_chk(0, 24'h000302, 16'h0012);
    rd_chk(0, 24'h000303, 16'h0000);
    // offsets outside the pointer and data port go to the controller, one read strobe per cycle
    host.start(0, 24'h000300, 16'h0000);
    #1 chk("io_reg_rd", {15'h0, io_reg_rd}, 16'h1);
    chk("io_reg_index rd", {12'h0, io_reg_index}, 16'h0000);
    repeat (2) @(posedge mclk);
    #1 chk("register read data", data_out, 16'h00C3);
    chk("io_reg_rd once", {15'h0, io_reg_rd}, 16'h0);
    host.stop();
    @(posedge mclk);
    cfg_wide <= 1'b1;
    io_wr(4'h2, 8'h20);
    host.start(1, {8'h00, 12'h030, 4'h4}, 16'hC0DE);
    host.stop();
    io_wr(4'h2, 8'h20);
    rd_chk(0, 24'h000304, 16'hC0DE);
    rd_chk(0, 24'h000302, 16'h0022);
  endtask

  task automatic t_wide_strap();
    @(posedge mclk);
    cfg_io <= 1'b0;
    cfg_wide <= 1'b0;
    do_reset(1'b1);
    sel_chk(24'h0D0000, 1'b1, 1'b0);
    host.start(3, 24'h0D0004, 16'hBEEF);
    host.stop();
    rd_chk(2, 24'h0D0004, 16'hBEEF);
  endtask

  initial begin
    #100000;
    err_total++;
    print_verdict();
  end

  initial begin
    do_reset(1'b0);
    t_io_decode();
    t_irq_leds();
    t_mem();
    t_io_seq();
    t_wide_strap();
    print_verdict();
  end
endmodule // testbench
